// File: hdl/bcp_pkg.sv
// bcp_pkg: constants and types of the channel program register bank
// assumes nothing beyond a SystemVerilog compiler
package bcp_pkg;

  // ***********************************************************
  // geometry and sub-addresses
  // ***********************************************************
  localparam int unsigned NUM_CH = 8;
  localparam logic [7:0] SUB_GLOBAL = 8'h00;
  localparam logic [7:0] SUB_CH_FIRST = 8'h01;
  localparam logic [7:0] SUB_CH_LAST = 8'h08;
  // serial device address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // ***********************************************************
  // program register layout and reset values
  // ***********************************************************
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_FCCM = 6;
  localparam int unsigned BIT_PHASE_HI = 5;
  localparam int unsigned BIT_PHASE_LO = 4;
  localparam int unsigned BIT_FB_HI = 3;
  localparam int unsigned BIT_FB_LO = 0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_FCCM = 1'b0;
  localparam logic [3:0] RST_FB_CODE = 4'hc;
  // per-channel phase defaults, channel 1 in the low pair
  localparam logic [15:0] RST_PHASE_ALL = 16'he4e4;

  // global register: all zero at reset; chosen field positions
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam int unsigned GBIT_IGNORE_EN = 3;
  localparam int unsigned GBIT_PULLDOWN = 2;
  localparam int unsigned GBIT_SLOW_EDGE = 1;

  // ***********************************************************
  // feedback reference mapping, millivolts
  // ***********************************************************
  localparam logic [9:0] FB_MIN_MV = 10'h1a9; // 425
  localparam logic [9:0] FB_STEP_MV = 10'h019; // 25

  // ***********************************************************
  // switching clock and phase timing
  // ***********************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SW_PERIOD_NS = 500;
  localparam int unsigned SW_QUARTER_CYC =
    (SW_PERIOD_NS * 1000) / CLK_PERIOD_PS / 4;

  // ***********************************************************
  // capacitor-scaled intervals, ms per nF
  // ***********************************************************
  localparam logic [4:0] RST_MS_PER_NF = 5'h17; // 23
  localparam logic [4:0] PB_LO_MS_PER_NF = 5'h05;
  localparam logic [4:0] IRQ_PW_MS_PER_NF = 5'h05;

  typedef struct packed {
    logic enable;
    logic fccm;
    logic [1:0] phase;
    logic [3:0] fb_code;
  } bcp_prog_t;

  typedef enum logic [7:0] {
    BCP_IDLE = 8'h01,
    BCP_ADDR = 8'h02,
    BCP_ACK_A = 8'h04,
    BCP_SUB = 8'h08,
    BCP_ACK_S = 8'h10,
    BCP_DATA = 8'h20,
    BCP_READ = 8'h40,
    BCP_RACK = 8'h80
  } bcp_state_t;

  function automatic logic [9:0] bcp_fb_mv(input logic [3:0] code);
    bcp_fb_mv = FB_MIN_MV + 10'(code * FB_STEP_MV);
  endfunction

  function automatic logic [19:0] bcp_scale(input logic [11:0] ct_nf,
                                            input logic [4:0] k);
    bcp_scale = 20'(ct_nf * k);
  endfunction

endpackage

// File: hdl/bcp_sync3.sv
// bcp_sync3: three-stage input synchroniser with agreement filter
// assumes asynchronous inputs and a single core clock
`timescale 1ns/1ps
`default_nettype none
module bcp_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit only moves once stages two and three agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // bcp_sync3
`default_nettype wire

// File: hdl/bcp_regs.sv
// bcp_regs: serial-programmed channel and global registers of an
// eight-channel step-down converter, with per-channel outputs
// assumes open-drain serial pins resolved outside; core_clk 250 MHz
//
// Behaviour
// - enable bit 7 resets to zero; regulator off unless enabled otherwise.
// - enable pin also turns regulator on, using its program register, unless global bit 3 is set.
// - mode bit 6 zero selects pulse skipping, one forced continuous.
// - phase code sets switch-high delay 0, 90, 180, 270 degrees.
// - channel n loads phase default (n-1) mod 4 at reset; channels n and n+4 share one.
// - feedback code maps linearly, 425 mV plus 25 mV per step.
// - feedback code resets to 1100, 725 mV.
// - global register resets to zero and acts on all channels.
// - pushbutton, pulse and reset intervals scale with timing capacitor.
// - channel n program register sits at sub-address n, 01h to 08h.
`timescale 1ns/1ps
`default_nettype none
module bcp_regs
  import bcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [NUM_CH-1:0] en_pin,
  input wire logic [11:0] ct_nf,
  output bcp_prog_t [NUM_CH-1:0] ch_prog,
  output logic [NUM_CH-1:0] ch_on,
  output logic [NUM_CH-1:0] ch_fccm,
  output logic [NUM_CH-1:0] sw_start,
  output logic [NUM_CH*10-1:0] ch_ref_mv,
  output logic [7:0] global_cfg,
  output logic sw_pulldown,
  output logic sw_slow_edge,
  output logic [19:0] rst_ms,
  output logic [19:0] pb_lo_ms,
  output logic [19:0] irq_pw_ms
);

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic scl_f, sda_f;
  logic [NUM_CH-1:0] en_f;
  bcp_sync3 #(.W(2), .INIT(2'h3)) u_sync_bus (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({scl_i, sda_i}),
    .level({scl_f, sda_f})
  );

  bcp_sync3 #(.W(NUM_CH), .INIT('0)) u_sync_en (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(en_pin),
    .level(en_f)
  );

  logic scl_q_reg, sda_q_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_f & ~scl_q_reg;
  assign scl_fall = ~scl_f & scl_q_reg;
  assign bus_start = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  assign bus_stop = scl_f & scl_q_reg & ~sda_q_reg & sda_f;

  // ***********************************************************
  // serial slave
  // ***********************************************************
  bcp_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg, sub_reg, tx_reg, rd_byte;
  logic rw_reg, nack_reg, drive_reg, wr_stb;
  function automatic logic sub_is_ch(input logic [7:0] a);
    sub_is_ch = (a >= SUB_CH_FIRST) && (a <= SUB_CH_LAST);
  endfunction
  // commit at the falling edge that ends the eighth data bit
  assign wr_stb = scl_fall && (state_reg == BCP_DATA) &&
                  (cnt_reg == 4'h8);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BCP_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sub_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg <= BCP_ADDR;
      cnt_reg <= 4'h0;
      drive_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= BCP_IDLE;
      drive_reg <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        BCP_ADDR, BCP_SUB, BCP_DATA: begin
          shift_reg <= {shift_reg[6:0], sda_f};
          cnt_reg <= cnt_reg + 4'h1;
        end
        BCP_RACK: nack_reg <= sda_f;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        BCP_ADDR: begin
          if (cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              state_reg <= BCP_ACK_A;
              rw_reg <= shift_reg[0];
              drive_reg <= 1'b1;
            end else begin
              state_reg <= BCP_IDLE;
            end
          end
        end
        BCP_ACK_A: begin
          cnt_reg <= 4'h0;
          if (rw_reg) begin
            state_reg <= BCP_READ;
            tx_reg <= rd_byte;
            drive_reg <= ~rd_byte[7];
          end else begin
            state_reg <= BCP_SUB;
            drive_reg <= 1'b0;
          end
        end
        BCP_SUB: begin
          if (cnt_reg == 4'h8) begin
            sub_reg <= shift_reg;
            state_reg <= BCP_ACK_S;
            drive_reg <= 1'b1;
          end
        end
        BCP_ACK_S: begin
          cnt_reg <= 4'h0;
          state_reg <= BCP_DATA;
          drive_reg <= 1'b0;
        end
        BCP_DATA: begin
          if (cnt_reg == 4'h8) begin
            // acknowledge and step to the next sub-address
            state_reg <= BCP_ACK_S;
            sub_reg <= sub_reg + 8'h01;
            drive_reg <= 1'b1;
          end
        end
        BCP_READ: begin
          if (cnt_reg == 4'h7) begin
            state_reg <= BCP_RACK;
            sub_reg <= sub_reg + 8'h01;
            drive_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
            tx_reg <= {tx_reg[6:0], 1'b0};
            drive_reg <= ~tx_reg[6];
          end
        end
        BCP_RACK: begin
          cnt_reg <= 4'h0;
          if (nack_reg) begin
            state_reg <= BCP_IDLE;
          end else begin
            state_reg <= BCP_READ;
            tx_reg <= rd_byte;
            drive_reg <= ~rd_byte[7];
          end
        end
        BCP_IDLE: ;
      endcase
    end
  end
  // open drain: only ever pull low, enable active low
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive_reg;

  // ***********************************************************
  // register storage
  // ***********************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_prog[i].enable <= RST_ENABLE;
        ch_prog[i].fccm <= RST_FCCM;
        ch_prog[i].phase <= RST_PHASE_ALL[2*i +: 2];
        ch_prog[i].fb_code <= RST_FB_CODE;
      end
    end else if (wr_stb && sub_is_ch(sub_reg)) begin
      // sub-address n selects channel n
      ch_prog[3'(sub_reg - SUB_CH_FIRST)] <= shift_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      global_cfg <= RST_GLOBAL;
    end else if (wr_stb && (sub_reg == SUB_GLOBAL)) begin
      global_cfg <= shift_reg;
    end
  end

  // unmapped sub-addresses read as zero and ignore writes
  always_comb begin
    rd_byte = 8'h00;
    if (sub_reg == SUB_GLOBAL) begin
      rd_byte = global_cfg;
    end else if (sub_is_ch(sub_reg)) begin
      rd_byte = ch_prog[3'(sub_reg - SUB_CH_FIRST)];
    end
  end

  // ***********************************************************
  // channel controls
  // ***********************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch_on <= '0;
      ch_fccm <= '0;
      ch_ref_mv <= '0;
      sw_pulldown <= 1'b0;
      sw_slow_edge <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // pin enable still obeys the register's other fields
        ch_on[i] <= ch_prog[i].enable |
                    (en_f[i] & ~global_cfg[GBIT_IGNORE_EN]);
        ch_fccm[i] <= ch_prog[i].fccm;
        ch_ref_mv[10*i +: 10] <= bcp_fb_mv(ch_prog[i].fb_code);
      end
      sw_pulldown <= global_cfg[GBIT_PULLDOWN];
      sw_slow_edge <= global_cfg[GBIT_SLOW_EDGE];
    end
  end

  // ***********************************************************
  // switching clock quarters and phase starts
  // ***********************************************************
  logic [15:0] qcnt_reg;
  logic [1:0] quad_reg;
  logic quad_tick;
  assign quad_tick = (qcnt_reg == 16'(SW_QUARTER_CYC - 1));
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      qcnt_reg <= 16'h0000;
      quad_reg <= 2'h0;
    end else if (quad_tick) begin
      qcnt_reg <= 16'h0000;
      quad_reg <= quad_reg + 2'h1;
    end else begin
      qcnt_reg <= qcnt_reg + 16'h0001;
    end
  end
  // quadrant 0 start is the internal clock rising edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_start <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        sw_start[i] <= quad_tick && ch_on[i] &&
                       ((quad_reg + 2'h1) == ch_prog[i].phase);
      end
    end
  end

  // ***********************************************************
  // capacitor-scaled intervals
  // ***********************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_ms <= 20'h00000;
      pb_lo_ms <= 20'h00000;
      irq_pw_ms <= 20'h00000;
    end else begin
      rst_ms <= bcp_scale(ct_nf, RST_MS_PER_NF);
      pb_lo_ms <= bcp_scale(ct_nf, PB_LO_MS_PER_NF);
      irq_pw_ms <= bcp_scale(ct_nf, IRQ_PW_MS_PER_NF);
    end
  end

endmodule // bcp_regs
`default_nettype wire

// File: dv/bcp_host.sv
// bcp_host: serial bus host that writes program bytes into the bank
// assumes an open-drain data wire with pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module bcp_host (
  input wire logic core_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  // half bit time kept above the ten clocks the receiver needs
  localparam int HALF = 12;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // data moves only while scl is low, two clocks after its fall
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tick(2);
      sda = b[i];
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      scl = 1'b0;
    end
    tick(2);
    sda = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    ack = !sda_w;
    scl = 1'b0;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub,
                    input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    a1 = 1'b0;
    a2 = 1'b0;
    tick(HALF);
    sda = 1'b0;
    tick(HALF);
    scl = 1'b0;
    send({dev, 1'b0}, a0);
    if (a0) begin
      send(sub, a1);
      send(data, a2);
    end
    tick(2);
    sda = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda = 1'b1;
    ok = a0 & a1 & a2;
  endtask
  // read one byte: sub-address, repeated start, then master nack
  task automatic rd(input logic [6:0] dev, input logic [7:0] sub,
                    output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    a1 = 1'b0;
    a2 = 1'b0;
    data = 8'h00;
    tick(HALF);
    sda = 1'b0;
    tick(HALF);
    scl = 1'b0;
    send({dev, 1'b0}, a0);
    if (a0) begin
      send(sub, a1);
      tick(2);
      sda = 1'b1;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      sda = 1'b0;
      tick(HALF);
      scl = 1'b0;
      send({dev, 1'b1}, a2);
      // data line stays released; the bank drives each bit
      for (int i = 7; i >= 0; i--) begin
        tick(2 + HALF);
        scl = 1'b1;
        tick(HALF);
        data[i] = sda_w;
        scl = 1'b0;
      end
      tick(2 + HALF);
      scl = 1'b1;
      tick(HALF);
      scl = 1'b0;
    end
    tick(2);
    sda = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda = 1'b1;
    ok = a0 & a1 & a2;
  endtask
endmodule // bcp_host
`default_nettype wire

// File: dv/bcp_regs_sva.sv
// bcp_regs_sva: timing relations at the ports of the register bank
// assumes one clock domain and the bind below
`timescale 1ns/1ps
`default_nettype none
module bcp_regs_sva
  import bcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire bcp_prog_t [NUM_CH-1:0] ch_prog,
  input wire logic [NUM_CH-1:0] ch_on,
  input wire logic [NUM_CH-1:0] ch_fccm,
  input wire logic [NUM_CH-1:0] sw_start,
  input wire logic [NUM_CH*10-1:0] ch_ref_mv,
  input wire logic [7:0] global_cfg,
  input wire logic sw_pulldown,
  input wire logic sw_slow_edge,
  input wire logic [11:0] ct_nf,
  input wire logic [19:0] rst_ms,
  input wire logic [19:0] pb_lo_ms
);
  logic [7:0] en_b, fc_b;
  logic [79:0] ref_exp;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      en_b[i] = ch_prog[i].enable;
      fc_b[i] = ch_prog[i].fccm;
      ref_exp[i*10 +: 10] = 10'(425 + 25 * ch_prog[i].fb_code);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_RST_VAL: assert property (
    $rose(nrst) |-> ch_prog == 64'h3c2c1c0c_3c2c1c0c && ch_on == 8'h00)
    else $error("reset values of program registers wrong");
  AST_GLB_RST: assert property (
    $rose(nrst) |-> global_cfg == 8'h00 && !sw_pulldown)
    else $error("global register not zero after reset");
  AST_EN_ON: assert property (
    en_b != 8'h00 |=> (ch_on & $past(en_b)) == $past(en_b))
    else $error("enabled channel not on");
  AST_IGN_PINS: assert property (
    global_cfg[3] [*2] |=> ch_on == $past(en_b))
    else $error("channel on state ignores enable bits");
  AST_MODE: assert property (
    $stable(fc_b) [*2] |-> ch_fccm == fc_b)
    else $error("mode output differs from mode bits");
  AST_REF: assert property (
    1'b1 |=> ch_ref_mv == $past(ref_exp))
    else $error("reference millivolts wrong");
  AST_TIMING: assert property (
    1'b1 |=> rst_ms == 20'($past(ct_nf) * 23) &&
             pb_lo_ms == 20'($past(ct_nf) * 5))
    else $error("capacitor intervals wrong");
  AST_SW_ON: assert property (
    (sw_start & ~ch_on & ~$past(ch_on)) == 8'h00)
    else $error("switch pulse on a channel that is off");
  AST_PERIOD: assert property (
    sw_start[0] |-> ##124 (sw_start[0] || !ch_on[0] ||
      $past(ch_prog[0].phase, 124) != ch_prog[0].phase))
    else $error("switch period not four quarters");
  AST_PH_STEP: assert property (
    sw_start[0] && ch_on[1] && ch_prog[1].phase == ch_prog[0].phase + 2'd1
    |-> ##31 (sw_start[1] || !ch_on[1] ||
      $past(ch_prog[1].phase, 31) != ch_prog[1].phase))
    else $error("quarter phase step not 31 clocks");
  COV_SW: cover property (sw_start[0] && sw_start[1]);
  COV_ACK: cover property (!sda_oe_n && !sda_o);
  COV_IGN: cover property (global_cfg[3] && ch_on[7]);
endmodule // bcp_regs_sva
bind bcp_regs bcp_regs_sva u_sva (.core_clk(core_clk), .nrst(nrst),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .ch_prog(ch_prog), .ch_on(ch_on),
  .ch_fccm(ch_fccm), .sw_start(sw_start), .ch_ref_mv(ch_ref_mv),
  .global_cfg(global_cfg), .sw_pulldown(sw_pulldown),
  .sw_slow_edge(sw_slow_edge), .ct_nf(ct_nf), .rst_ms(rst_ms),
  .pb_lo_ms(pb_lo_ms));
`default_nettype wire

// File: dv/buck_channel_program_regs_test.sv
// buck_channel_program_regs_test: writes the bank over the serial bus
// and compares every output except sw_start with an integer model of the registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("unexpected at %0t: %s", $time, m); \
  end \
end
module buck_channel_program_regs_test
  import bcp_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst, scl, sda_h, sda_o, sda_oe_n, sda_w;
  logic [7:0] en_pin, global_cfg;
  logic [11:0] ct_nf;
  bcp_prog_t [7:0] ch_prog;
  logic [7:0] ch_on, ch_fccm, sw_start;
  logic [79:0] ch_ref_mv;
  logic sw_pulldown, sw_slow_edge;
  logic [19:0] rst_ms, pb_lo_ms, irq_pw_ms;
  int fail_count = 0;
  int comparisons = 0;
  int prog_m [8];
  int glob_m;
  // wired-and of the open-drain bus with its pull-up
  assign sda_w = sda_h & (sda_oe_n | sda_o);
  always #2 core_clk = ~core_clk;
  bcp_host host (.core_clk(core_clk), .sda_w(sda_w), .scl(scl),
    .sda(sda_h));
  bcp_regs dut (.core_clk(core_clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .en_pin(en_pin),
    .ct_nf(ct_nf), .ch_prog(ch_prog), .ch_on(ch_on), .ch_fccm(ch_fccm),
    .sw_start(sw_start), .ch_ref_mv(ch_ref_mv), .global_cfg(global_cfg),
    .sw_pulldown(sw_pulldown), .sw_slow_edge(sw_slow_edge),
    .rst_ms(rst_ms), .pb_lo_ms(pb_lo_ms), .irq_pw_ms(irq_pw_ms));
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************************
  // model comparison; pins need a few clocks to pass sync
  // ****************************************************
  task automatic check_all();
    host.tick(8);
    for (int i = 0; i < 8; i++) begin
      `CHK(ch_prog[i], 8'(prog_m[i]), "program")
      `CHK(ch_ref_mv[i*10 +: 10], 10'(425 + 25 * (prog_m[i] & 15)), "mv")
      `CHK(ch_fccm[i], prog_m[i][6], "mode")
      `CHK(ch_on[i], prog_m[i][7] | (en_pin[i] & ~glob_m[3]), "on")
    end
    `CHK(global_cfg, 8'(glob_m), "global")
    `CHK(sw_pulldown, glob_m[2], "pulldown")
    `CHK(sw_slow_edge, glob_m[1], "slow edge")
    `CHK(rst_ms, 20'(ct_nf * 23), "reset interval")
    `CHK(irq_pw_ms, 20'(ct_nf * 5), "pulse interval")
    `CHK(pb_lo_ms, 20'(ct_nf * 5), "pushbutton interval")
  endtask
  initial begin
    int d, n;
    logic ok;
    logic [7:0] rb;
    void'($urandom(9015));
    nrst = 1'b0;
    en_pin = 8'h00;
    ct_nf = 12'($urandom);
    glob_m = 0;
    for (int i = 0; i < 8; i++) prog_m[i] = 'h0c | ((i % 4) << 4);
    host.tick(6);
    nrst = 1'b1;
    check_all();
    for (int c = 1; c <= 8; c++) begin
      d = $urandom & 'hff;
      prog_m[c-1] = d;
      en_pin = 8'($urandom);
      ct_nf = 12'($urandom);
      host.wr(DEV_ADDR, 8'(c), 8'(d), ok);
      `CHK(ok, 1'b1, "no ack")
      check_all();
      host.rd(DEV_ADDR, 8'(c), rb, ok);
      `CHK({ok, rb}, {1'b1, 8'(d)}, "read back")
    end
    for (int k = 0; k < 2; k++) begin
      glob_m = ($urandom & 'hf7) | (k << 3);
      host.wr(DEV_ADDR, SUB_GLOBAL, 8'(glob_m), ok);
      check_all();
      host.rd(DEV_ADDR, SUB_GLOBAL, rb, ok);
      `CHK({ok, rb}, {1'b1, 8'(glob_m)}, "global read")
    end
    host.wr(DEV_ADDR, 8'h09, 8'h5a, ok);
    check_all();
    host.rd(DEV_ADDR, 8'h09, rb, ok);
    `CHK({ok, rb}, 9'h100, "unmapped read")
    host.wr(DEV_ADDR ^ 7'h01, 8'h01, 8'h5a, ok);
    `CHK(ok, 1'b0, "foreign address acked")
    check_all();
    // channel 1 at phase 0 is the reference for channel 2
    glob_m = 8;
    host.wr(DEV_ADDR, SUB_GLOBAL, 8'h08, ok);
    prog_m[0] = 'h8c;
    host.wr(DEV_ADDR, 8'h01, 8'h8c, ok);
    for (int p = 0; p < 4; p++) begin
      prog_m[1] = 'h8c | (p << 4);
      host.wr(DEV_ADDR, 8'h02, 8'(prog_m[1]), ok);
      check_all();
      n = 0;
      while (sw_start[0] !== 1'b1 && n < 300) begin
        host.tick(1);
        n++;
      end
      `CHK(n < 300, 1'b1, "no reference pulse")
      n = 0;
      while (sw_start[1] !== 1'b1 && n < 300) begin
        host.tick(1);
        n++;
      end
      `CHK(n, 31 * p, "phase delay")
    end
    // a second reset mid-run must bring back every default
    nrst = 1'b0;
    host.tick(2);
    nrst = 1'b1;
    glob_m = 0;
    for (int i = 0; i < 8; i++) prog_m[i] = 'h0c | ((i % 4) << 4);
    check_all();
    report_and_stop();
  end
  // whole run is near 25000 clocks; allow about 2.4 times that
  initial begin
    #240000;
    fail_count++;
    report_and_stop();
  end
endmodule // buck_channel_program_regs_test
`default_nettype wire
